// ### rtl/psu_seq_pkg.sv
package psu_seq_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  // times in milliseconds as specified
  localparam int unsigned INPUT_GOOD_OUT_ON_MS = 1700;
  localparam int unsigned INPUT_GOOD_OUT_DIP_MS = 100;
  localparam int unsigned ON_DLY_MIN_MS = 5;
  localparam int unsigned ON_DLY_MAX_MS = 400;
  localparam int unsigned OFF_DLY_MAX_MS = 100;
  localparam int unsigned PG_DLY_MIN_MS = 100;
  localparam int unsigned PG_DLY_MAX_MS = 500;
  localparam int unsigned PG_WARN_MS = 1;
  localparam int unsigned HOLD_V1_MS = 7;
  localparam int unsigned HOLD_VSB_MS = 27;
  localparam int unsigned MIN_OFF_MS = 500;
  // chosen delays inside the allowed windows
  localparam int unsigned ON_DLY_MS = 10;
  localparam int unsigned PG_DLY_MS = 200;
  localparam int unsigned INPUT_GOOD_OUT_DLY_MS = 50;
  localparam int unsigned OFF_DLY_MS = 1;
  // inlet warning threshold in 0.5 degC steps: 62.5 degC
  localparam logic [9:0] INLET_WARN_HALF_C = 10'h07d;
  localparam int unsigned BLINK_1HZ_HALF_MS = 500;
  localparam int unsigned BLINK_2HZ_HALF_MS = 250;
  localparam logic [7:0] FAN_MAX = 8'hff;
  localparam logic [8:0] TRIM_MAX_MV = 9'h0fa;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_WAIT_ON = 3'b001,
    ST_ON = 3'b010,
    ST_PG_DROP = 3'b011,
    ST_MIN_OFF = 3'b100
  } main_state_e;

  typedef enum logic [1:0] {
    LED_DARK = 2'b00,
    LED_GREEN = 2'b01,
    LED_AMBER = 2'b10
  } led_color_e;

  typedef struct packed {
    logic hot_spot_warn;
    logic hot_spot_shut;
    logic general_fail;
    logic overcurrent_trip;
    logic overvoltage_trip;
    logic undervoltage_trip;
    logic high_current_warn;
    logic fan_slow;
    logic fan_fail;
  } fault_in_s;
endpackage

// ### rtl/psu_status_signalling_sequencer.sv
`timescale 1ns/10ps
// Summary of operation
// RL1: alert_out_n is low when any shutdown or warning event is present; the code pulls it low for a warning only once fan_cmd is at FAN_MAX.
// RL2: temperature, general fail, over-current, over/under-voltage, fan faults pull alert.
// RL3: while alert is asserted the LED shows solid amber.
// RL4: inlet above 62.5 C or hot-spot warning raises over-temperature alert.
// RL5: inlet warning clears once inlet temperature returns into operating range.
// RL6: fan command reaches maximum before the over-temperature alert asserts.
// RL7: presence output is held permanently low.
// RL8: share pin disconnected on internal fault or main output off.
// RL9: largest-current unit is master; followers trim up by at most 250 mV.
// RL10: LED off without input power, solid green when main output ok.
// RL11: LED off when own input lost even if another supply has input.
// RL12: input present with only standby on blinks green at 1 Hz.
// RL13: warnings with supply running blink amber at 1 Hz.
// RL14: critical shutdown events give solid amber.
// RL15: firmware upload mode blinks green at 2 Hz.
// RL16: input-good rises within 1700 ms at start, within 100 ms after a dip.
// RL17: main output turns on 5 to 400 ms after enable goes low.
// RL18: main output turns off within 100 ms after enable goes high.
// RL19: power-good rises 100 to 500 ms after main output is in regulation.
// RL20: power-good falls at least 1 ms before main output leaves regulation.
// RL21: input-good falls 7 ms before main and 27 ms before standby hold-up ends.
// RL22: main and standby stay off at least 500 ms before restarting.
// RL23: enable_n switches main output; any enable transition clears latched faults.
// RL24: power-good high only while all outputs regulate; low on dropout or long loss.
// RL25: input-good is active high, meaning input is within operating range.
// RL26: LED precedence: upload, critical, warning, off (no input), output ok, standby.
// RL27: blink patterns are 50 percent duty from a free-running divider.
module psu_status_signalling_sequencer
  import psu_seq_pkg::*;
#(
  parameter int unsigned INPUT_GOOD_OUT_ON_CYC = INPUT_GOOD_OUT_DLY_MS * CYC_PER_MS,
  parameter int unsigned ON_CYC = ON_DLY_MS * CYC_PER_MS,
  parameter int unsigned OFF_CYC = OFF_DLY_MS * CYC_PER_MS,
  parameter int unsigned PG_CYC = PG_DLY_MS * CYC_PER_MS,
  parameter int unsigned MIN_OFF_CYC = MIN_OFF_MS * CYC_PER_MS,
  parameter int unsigned PG_WARN_CYC = PG_WARN_MS * CYC_PER_MS,
  parameter int unsigned BLINK1_CYC = BLINK_1HZ_HALF_MS * CYC_PER_MS,
  parameter int unsigned BLINK2_CYC = BLINK_2HZ_HALF_MS * CYC_PER_MS
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic input_in_range,
  input wire logic input_dip_warn,
  input wire logic output_enable_n,
  input wire logic main_in_reg,
  input wire logic standby_in_reg,
  input wire logic [9:0] inlet_temp,
  input wire fault_in_s faults,
  input wire logic fw_upload,
  input wire logic share_is_max,
  input wire logic [8:0] share_trim_req,
  output logic alert_out_n,
  output logic power_good_out,
  output logic input_good_out,
  output logic main_output,
  output logic standby_output,
  output logic present_out_n,
  output logic current_share_en,
  output logic share_master,
  output logic [8:0] share_trim_mv,
  output logic [7:0] fan_cmd,
  output logic led_green,
  output logic led_amber
);
  localparam int CW = 32;

  logic [CW-1:0] seq_cnt_q;
  logic [CW-1:0] input_good_out_cnt_q;
  logic [CW-1:0] blink_cnt_q;
  logic blink1_q;
  logic blink2_q;
  logic [CW-1:0] blink2_cnt_q;
  main_state_e state_q;
  logic en_prev_q;
  logic latched_q;
  logic inlet_warn_q;
  logic ever_good_q;
  logic [CW-1:0] stb_off_cnt_q;

  wire en_edge = output_enable_n != en_prev_q;
  wire temp_warn_raw = inlet_warn_q | faults.hot_spot_warn;
  wire critical = faults.hot_spot_shut | faults.overcurrent_trip | faults.overvoltage_trip
      | faults.fan_fail | faults.general_fail | faults.undervoltage_trip;
  wire warn_any = temp_warn_raw | faults.high_current_warn | faults.fan_slow;
  // a warning-only alert holds off until the fan has reached full speed; critical events alert at once
  wire alert_now = critical | latched_q | (warn_any & (fan_cmd == FAN_MAX)); // [RL1] [RL2] [RL6]

  // inlet warning with hysteresis-free return once back in range
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      inlet_warn_q <= 1'b0;
    end else begin
      inlet_warn_q <= inlet_temp >= INLET_WARN_HALF_C; // [RL4] [RL5]
    end
  end

  // fan ramps one step per cycle toward maximum while any warning (temperature, high current, fan slow) stands
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fan_cmd <= 8'h00;
    end else if (temp_warn_raw || warn_any) begin
      if (fan_cmd != FAN_MAX) begin
        fan_cmd <= fan_cmd + 8'h01; // [RL6]
      end
    end else if (fan_cmd != 8'h00) begin
      fan_cmd <= fan_cmd - 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      alert_out_n <= 1'b1;
    end else begin
      alert_out_n <= ~alert_now; // [RL1]
    end
  end

  // enable edge clears latched shutdown; the set wins in the same cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      en_prev_q <= 1'b1;
      latched_q <= 1'b0;
    end else begin
      en_prev_q <= output_enable_n;
      if (critical) begin
        latched_q <= 1'b1;
      end else if (en_edge) begin
        latched_q <= 1'b0; // [RL23]
      end
    end
  end

  // input-good: delay on rising, drop early so it leads hold-up end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      input_good_out_cnt_q <= '0;
      input_good_out <= 1'b0;
      ever_good_q <= 1'b0;
    end else if (!input_in_range || input_dip_warn) begin
      input_good_out_cnt_q <= '0;
      input_good_out <= 1'b0; // [RL21] [RL25]
    end else if (input_good_out_cnt_q >= CW'(INPUT_GOOD_OUT_ON_CYC)) begin
      input_good_out <= 1'b1; // [RL16]
      ever_good_q <= 1'b1;
    end else begin
      input_good_out_cnt_q <= input_good_out_cnt_q + 1'b1;
    end
  end

  wire main_ok = input_good_out & ~latched_q & ~critical & ~output_enable_n;

  // main output sequencing with minimum off time
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_OFF;
      seq_cnt_q <= '0;
      main_output <= 1'b0;
      power_good_out <= 1'b0;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          seq_cnt_q <= '0;
          if (main_ok) begin
            state_q <= ST_WAIT_ON;
          end
        end
        ST_WAIT_ON: begin
          if (!main_ok) begin
            state_q <= ST_OFF;
          end else if (seq_cnt_q >= CW'(ON_CYC)) begin
            main_output <= 1'b1; // [RL17]
            state_q <= ST_ON;
            seq_cnt_q <= '0;
          end else begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
          end
        end
        ST_ON: begin
          if (!main_ok || !main_in_reg || !standby_in_reg) begin
            power_good_out <= 1'b0; // [RL20] [RL24]
            state_q <= ST_PG_DROP;
            seq_cnt_q <= '0;
          end else if (seq_cnt_q >= CW'(PG_CYC)) begin
            power_good_out <= 1'b1; // [RL19]
          end else begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
          end
        end
        ST_PG_DROP: begin
          // main stays up for the warning interval after power-good falls
          if (seq_cnt_q >= CW'(PG_WARN_CYC) && seq_cnt_q >= CW'(OFF_CYC)) begin
            main_output <= 1'b0; // [RL18] [RL20]
            state_q <= ST_MIN_OFF;
            seq_cnt_q <= '0;
          end else begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
          end
        end
        ST_MIN_OFF: begin
          if (seq_cnt_q >= CW'(MIN_OFF_CYC)) begin
            state_q <= ST_OFF; // [RL22]
          end else begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= ST_OFF;
          main_output <= 1'b0;
          power_good_out <= 1'b0;
        end
      endcase
    end
  end

  // standby follows input; once off it stays off for the minimum time
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      standby_output <= 1'b0;
      stb_off_cnt_q <= '0;
    end else if (standby_output) begin
      if (!input_in_range) begin
        standby_output <= 1'b0;
        stb_off_cnt_q <= '0;
      end
    end else if (stb_off_cnt_q < CW'(MIN_OFF_CYC)) begin
      stb_off_cnt_q <= stb_off_cnt_q + 1'b1;
    end else if (input_in_range) begin
      standby_output <= 1'b1; // [RL22]
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      present_out_n <= 1'b0;
    end else begin
      present_out_n <= 1'b0; // [RL7]
    end
  end

  // current share attach and follower trim
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      current_share_en <= 1'b0;
      share_master <= 1'b0;
      share_trim_mv <= 9'h000;
    end else begin
      current_share_en <= main_output & ~critical & ~latched_q; // [RL8]
      share_master <= share_is_max; // [RL9]
      if (share_is_max || !main_output) begin
        share_trim_mv <= 9'h000;
      end else if (share_trim_req > TRIM_MAX_MV) begin
        share_trim_mv <= TRIM_MAX_MV; // [RL9]
      end else begin
        share_trim_mv <= share_trim_req;
      end
    end
  end

  // free-running blink dividers, toggle each half period
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      blink_cnt_q <= '0;
      blink2_cnt_q <= '0;
      blink1_q <= 1'b0;
      blink2_q <= 1'b0;
    end else begin
      if (blink_cnt_q >= CW'(BLINK1_CYC - 1)) begin
        blink_cnt_q <= '0;
        blink1_q <= ~blink1_q; // [RL27]
      end else begin
        blink_cnt_q <= blink_cnt_q + 1'b1;
      end
      if (blink2_cnt_q >= CW'(BLINK2_CYC - 1)) begin
        blink2_cnt_q <= '0;
        blink2_q <= ~blink2_q; // [RL27]
      end else begin
        blink2_cnt_q <= blink2_cnt_q + 1'b1;
      end
    end
  end

  // amber solid whenever alert is low outside firmware upload, so a running warning only blinks before it alerts
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      led_green <= 1'b0;
      led_amber <= 1'b0;
    end else if (fw_upload) begin
      led_green <= blink2_q; // [RL15] [RL26]
      led_amber <= 1'b0;
    end else if (critical || latched_q || alert_now) begin
      led_green <= 1'b0;
      led_amber <= 1'b1; // [RL3] [RL14]
    end else if (warn_any) begin
      led_green <= 1'b0;
      led_amber <= blink1_q; // [RL13]
    end else if (!input_in_range) begin
      led_green <= 1'b0; // [RL10] [RL11]
      led_amber <= 1'b0;
    end else if (power_good_out) begin
      led_green <= 1'b1; // [RL10]
      led_amber <= 1'b0;
    end else begin
      led_green <= blink1_q; // [RL12]
      led_amber <= 1'b0;
    end
  end
endmodule // psu_status_signalling_sequencer

// ### testbench/psu_seq_properties.sv
`timescale 1ns/10ps
module psu_seq_properties
  import psu_seq_pkg::*;
#(
  parameter int unsigned ON_CYC = 20,
  parameter int unsigned PG_CYC = 30,
  parameter int unsigned MIN_OFF_CYC = 40,
  parameter int unsigned PG_WARN_CYC = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic input_in_range,
  input wire logic output_enable_n,
  input wire logic main_in_reg,
  input wire logic standby_in_reg,
  input wire logic [9:0] inlet_temp,
  input wire fault_in_s faults,
  input wire logic alert_out_n,
  input wire logic power_good_out,
  input wire logic input_good_out,
  input wire logic main_output,
  input wire logic present_out_n,
  input wire logic current_share_en,
  input wire logic [8:0] share_trim_mv,
  input wire logic [7:0] fan_cmd,
  input wire logic led_amber
);
  logic crit;
  logic [15:0] en_q, on_q, off_q, pgl_q;
  assign crit = faults.overcurrent_trip | faults.overvoltage_trip | faults.undervoltage_trip
    | faults.general_fail | faults.hot_spot_shut | faults.fan_fail;
  // off counter starts full so the first start after reset is not held to min-off
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      en_q <= '0;
      on_q <= '0;
      off_q <= 16'(MIN_OFF_CYC);
      pgl_q <= '0;
    end else begin
      en_q <= output_enable_n ? '0 : en_q + 16'h1;
      on_q <= main_output ? on_q + 16'h1 : '0;
      off_q <= main_output ? '0 : off_q + 16'h1;
      pgl_q <= power_good_out ? '0 : pgl_q + 16'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_present_low: assert property (present_out_n == 1'b0)
    else $error("presence output not low");
  a_crit_alert: assert property (crit |=> !alert_out_n)
    else $error("alert missing after critical event");
  a_alert_amber: assert property (!alert_out_n [*2] |-> led_amber)
    else $error("alert without amber");
  a_fan_first: assert property ($fell(alert_out_n) && !$past(crit) |-> fan_cmd == FAN_MAX)
    else $error("warning alert before fan at max");
  a_inlet_warn: assert property ($rose(inlet_temp > INLET_WARN_HALF_C) |->
    ##[1:260] (!alert_out_n || inlet_temp <= INLET_WARN_HALF_C))
    else $error("inlet warning not raised");
  a_on_delay: assert property ($rose(main_output) |-> en_q >= ON_CYC)
    else $error("main output on too early");
  a_off_delay: assert property ($rose(output_enable_n) |-> ##[1:12] !main_output)
    else $error("main output not off after disable");
  a_pg_delay: assert property ($rose(power_good_out) |-> on_q >= PG_CYC - 1)
    else $error("power good too early");
  a_pg_lead: assert property ($fell(main_output) |-> pgl_q >= PG_WARN_CYC)
    else $error("power good not dropped ahead of main");
  a_min_off: assert property ($rose(main_output) |-> off_q >= MIN_OFF_CYC)
    else $error("main restarted inside min off");
  a_pg_rails: assert property (!(main_in_reg && standby_in_reg) |=> !power_good_out)
    else $error("power good with rail out of regulation");
  a_input_good_out_loss: assert property (!input_in_range |=> !input_good_out)
    else $error("input good held with input lost");
  a_share_off: assert property (!main_output [*2] |-> !current_share_en)
    else $error("share pin attached while off");
  a_trim_max: assert property (share_trim_mv <= TRIM_MAX_MV)
    else $error("share trim above limit");
endmodule // psu_seq_properties

bind psu_status_signalling_sequencer psu_seq_properties #(.ON_CYC(ON_CYC), .PG_CYC(PG_CYC),
  .MIN_OFF_CYC(MIN_OFF_CYC), .PG_WARN_CYC(PG_WARN_CYC)) i_props (.sys_clk(sys_clk),
  .resetn(resetn), .input_in_range(input_in_range), .output_enable_n(output_enable_n),
  .main_in_reg(main_in_reg), .standby_in_reg(standby_in_reg), .inlet_temp(inlet_temp),
  .faults(faults), .alert_out_n(alert_out_n), .power_good_out(power_good_out),
  .input_good_out(input_good_out), .main_output(main_output), .present_out_n(present_out_n),
  .current_share_en(current_share_en), .share_trim_mv(share_trim_mv), .fan_cmd(fan_cmd),
  .led_amber(led_amber));

// ### testbench/host_model.sv
`timescale 1ns/10ps
module host_model (
  input wire logic en_req,
  input wire logic alert_out_n,
  input wire logic present_out_n,
  output logic output_enable_n,
  output logic alert_line,
  output logic seated
);
  assign output_enable_n = ~en_req;
  assign alert_line = alert_out_n;
  // host pull-up reads low only while a supply is seated
  assign seated = ~present_out_n;
endmodule // host_model

// ### testbench/testbench.sv
`timescale 1ns/10ps
module testbench
  import psu_seq_pkg::*;
;
  localparam int INPUT_GOOD_OUT = 20, ONC = 20, PGC = 30, MOFF = 40, B1 = 20, B2 = 10;
  logic sys_clk = 0, resetn = 0, input_in_range = 0, input_dip_warn = 0, fw_upload = 0;
  logic main_in_reg = 1, standby_in_reg = 1, share_is_max = 0, en_req = 0;
  logic [9:0] inlet_temp = 10'h050;
  fault_in_s faults = '0;
  logic [8:0] share_trim_req = 9'h12c;
  logic alert_out_n, power_good_out, input_good_out, main_output, standby_output;
  logic present_out_n, current_share_en, share_master, led_green, led_amber;
  logic output_enable_n, alert_line, seated;
  logic [8:0] share_trim_mv;
  logic [7:0] fan_cmd;
  int err_count = 0, checked = 0, cyc = 0, n, h;

  psu_status_signalling_sequencer #(.INPUT_GOOD_OUT_ON_CYC(INPUT_GOOD_OUT), .ON_CYC(ONC), .OFF_CYC(4),
    .PG_CYC(PGC), .MIN_OFF_CYC(MOFF), .PG_WARN_CYC(4), .BLINK1_CYC(B1), .BLINK2_CYC(B2))
  i_dut (.sys_clk(sys_clk), .resetn(resetn), .input_in_range(input_in_range),
    .input_dip_warn(input_dip_warn), .output_enable_n(output_enable_n),
    .main_in_reg(main_in_reg), .standby_in_reg(standby_in_reg), .inlet_temp(inlet_temp),
    .faults(faults), .fw_upload(fw_upload), .share_is_max(share_is_max),
    .share_trim_req(share_trim_req), .alert_out_n(alert_out_n),
    .power_good_out(power_good_out), .input_good_out(input_good_out),
    .main_output(main_output), .standby_output(standby_output),
    .present_out_n(present_out_n), .current_share_en(current_share_en),
    .share_master(share_master), .share_trim_mv(share_trim_mv), .fan_cmd(fan_cmd),
    .led_green(led_green), .led_amber(led_amber));
  host_model i_host (.en_req(en_req), .alert_out_n(alert_out_n),
    .present_out_n(present_out_n), .output_enable_n(output_enable_n),
    .alert_line(alert_line), .seated(seated));

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
  endtask

  task automatic half_per(ref logic s, output int k);
    int d;
    // first toggle may be a change of LED mode, so measure the third one
    wait_lvl(s, ~s, 100, d);
    wait_lvl(s, ~s, 100, d);
    wait_lvl(s, ~s, 100, k);
  endtask

  task automatic t_start();
    input_in_range = 1;
    wait_lvl(input_good_out, 1, 60, n);
    chk("input_good_out_on", n >= INPUT_GOOD_OUT && n <= INPUT_GOOD_OUT + 2, 1);
    wait_lvl(standby_output, 1, 80, n);
    chk("standby", standby_output, 1);
    half_per(led_green, h);
    chk("blink1", h, B1);
    chk("amber", led_amber, 0);
    en_req = 1;
    wait_lvl(main_output, 1, 100, n);
    chk("on_dly", n >= ONC && n <= ONC + 3, 1);
    wait_lvl(power_good_out, 1, 100, n);
    chk("pg_dly", n >= PGC - 1 && n <= PGC + 3, 1);
    repeat (2) @(negedge sys_clk);
    chk("green", {led_green, led_amber}, 2'b10);
    chk("share_en", current_share_en, 1);
  endtask

  task automatic t_share();
    share_is_max = 1;
    repeat (3) @(negedge sys_clk);
    chk("master", share_master, 1);
    share_is_max = 0;
    repeat (3) @(negedge sys_clk);
    chk("trim", share_trim_mv, TRIM_MAX_MV);
  endtask

  task automatic t_warn();
    faults.fan_slow = 1;
    half_per(led_amber, h);
    chk("warn_blink", h, B1);
    wait_lvl(alert_line, 0, 300, n);
    chk("fan_max", fan_cmd, FAN_MAX);
    chk("warn_led", {led_amber, main_output}, 2'b11);
    faults.fan_slow = 0;
    wait_lvl(alert_line, 1, 10, n);
    chk("warn_clr", alert_line, 1);
    inlet_temp = 10'h07c;
    repeat (300) @(negedge sys_clk);
    chk("inlet_low", alert_line, 1);
    inlet_temp = 10'h0c8;
    wait_lvl(alert_line, 0, 300, n);
    chk("inlet_hi", alert_line, 0);
    inlet_temp = 10'h050;
    wait_lvl(alert_line, 1, 10, n);
    chk("inlet_clr", alert_line, 1);
  endtask

  task automatic t_crit();
    faults.overcurrent_trip = 1;
    repeat (2) @(negedge sys_clk);
    chk("crit_led", {alert_out_n, led_amber, led_green}, 3'b010);
    wait_lvl(main_output, 0, 15, n);
    chk("crit_off", {main_output, power_good_out}, 2'b00);
    @(negedge sys_clk);
    chk("share_dis", current_share_en, 0);
    faults.overcurrent_trip = 0;
    repeat (100) @(negedge sys_clk);
    chk("latched", main_output, 0);
    en_req = 0;
    @(negedge sys_clk);
    en_req = 1;
    wait_lvl(main_output, 1, ONC + 10, n);
    chk("cleared", {main_output, alert_out_n}, 2'b11);
    wait_lvl(power_good_out, 1, 100, n);
    main_in_reg = 0;
    repeat (2) @(negedge sys_clk);
    chk("pg_rail", power_good_out, 0);
    main_in_reg = 1;
    wait_lvl(power_good_out, 1, 150, n);
    chk("pg_back", power_good_out, 1);
  endtask

  task automatic t_fw_off();
    fw_upload = 1;
    half_per(led_green, h);
    chk("blink2", h, B2);
    fw_upload = 0;
    en_req = 0;
    wait_lvl(main_output, 0, 12, n);
    chk("off_dly", main_output, 0);
    en_req = 1;
    wait_lvl(main_output, 1, 150, n);
    chk("min_off", n >= MOFF, 1);
  endtask

  task automatic t_loss();
    input_dip_warn = 1;
    repeat (2) @(negedge sys_clk);
    chk("dip", input_good_out, 0);
    input_dip_warn = 0;
    input_in_range = 0;
    repeat (60) @(negedge sys_clk);
    chk("dark", {led_green, led_amber}, 2'b00);
    input_in_range = 1;
    wait_lvl(input_good_out, 1, INPUT_GOOD_OUT + 5, n);
    chk("input_good_out_dip", input_good_out, 1);
  endtask

  initial begin
    repeat (5) @(negedge sys_clk);
    chk("rst", {alert_out_n, main_output, power_good_out, seated}, 4'b1001);
    resetn = 1;
    t_start();
    t_share();
    t_warn();
    t_crit();
    t_fw_off();
    t_loss();
    stop_test();
  end
endmodule // testbench
